// >>> design/window_watchdog_defines.vh
// Constants for the window watchdog timing block.
`ifndef WINDOW_WATCHDOG_DEFINES_VH
`define WINDOW_WATCHDOG_DEFINES_VH

// System clock period in nanoseconds (10 MHz).
`define CLK_PERIOD_NS      100
// Reset hold delay, typical, in nanoseconds (25 ms).
`define RESET_DELAY_NS     25000000
// Reset hold delay in system clock cycles.
`define RESET_DELAY_CYC    (`RESET_DELAY_NS / `CLK_PERIOD_NS)
// Period of one window oscillator cycle in nanoseconds (10 us).
`define OSC_TICK_NS        10000
// Window oscillator period in system clock cycles.
`define OSC_TICK_CYC       (`OSC_TICK_NS / `CLK_PERIOD_NS)

// Short fixed upper window, 0.25 s, in oscillator cycles.
`define WIN_SHORT_TICKS    32'h0000_61A8
// Long fixed upper window, 2.5 s, in oscillator cycles.
`define WIN_LONG_TICKS     32'h0003_D090
// Capacitor mode unit window, 6.25 ms, in oscillator cycles.
`define CAP_UNIT_TICKS     32'h0000_0271
// Capacitor scale, 15.55 pF, in hundredths of a picofarad.
`define CAP_SCALE_X100     32'h0000_0613
// Factor turning picofarads into hundredths of a picofarad.
`define CAP_PF_TO_X100     32'h0000_0064

// Lower boundary divisors, in tenths (124.9, 127.7, 64.5).
`define RATIO_HI_SHORT_X10 32'h0000_04E1
`define RATIO_HI_LONG_X10  32'h0000_04FD
`define RATIO_HI_CAP_X10   32'h0000_0285
// Lower boundary divisors, in tenths (31.8, 32, 25.8).
`define RATIO_LO_SHORT_X10 32'h0000_013E
`define RATIO_LO_LONG_X10  32'h0000_0140
`define RATIO_LO_CAP_X10   32'h0000_0102
// Factor of ten applied before dividing by a ratio in tenths.
`define RATIO_SCALE        32'h0000_000A

// Widths of the window counter and the capacitor value.
`define WIN_CNT_W          24
`define CAP_W              16

`endif

// >>> design/window_watchdog.v
// Window watchdog timing logic with reset pulse generation.
`timescale 1ns/1ns
`include "window_watchdog_defines.vh"

module window_watchdog #(
  parameter RESET_DELAY_CYC = `RESET_DELAY_CYC,
  parameter OSC_TICK_CYC    = `OSC_TICK_CYC
) (
  input  wire               clk,
  input  wire               rst,
  input  wire               trigger_input,
  input  wire               timeout_select,
  input  wire               cap_present,
  input  wire [`CAP_W-1:0]  cap_pf,
  input  wire               ratio_select,
  output reg                reset_n,
  output reg                reset_drive_n,
  output reg                early_fault,
  output reg                late_fault
);

  // One-hot states: hold the reset output, or run the window.
  localparam [1:0] ST_HOLD = 2'b01;
  localparam [1:0] ST_RUN  = 2'b10;

  reg [1:0]            state_q;      // Current state.
  reg [31:0]           hold_cnt_q;   // Reset delay counter.
  reg [31:0]           osc_cnt_q;    // Oscillator divider.
  reg                  osc_tick_q;   // One cycle per oscillator period.
  reg [`WIN_CNT_W-1:0] win_cnt_q;    // Oscillator cycles since restart.
  reg                  first_q;      // Lower check disabled while set.
  reg                  pend_q;       // Edge seen, waiting for a tick.
  reg [2:0]            trig_sync_q;  // Trigger synchroniser and history.
  reg [2:0]            cfg_meta_q;   // Strap synchroniser, first stage.
  reg [2:0]            cfg_sync_q;   // Strap synchroniser, second stage.
  reg [`CAP_W-1:0]     cap_meta_q;   // Capacitor value, first stage.
  reg [`CAP_W-1:0]     cap_sync_q;   // Capacitor value, second stage.
  reg                  cfg_long_q;   // Latched long-timeout strap.
  reg                  cfg_cap_q;    // Latched capacitor-mode strap.
  reg                  cfg_ratio_q;  // Latched ratio strap.
  reg [`CAP_W-1:0]     cfg_pf_q;     // Latched capacitor value.

  reg [31:0]           upper_w;      // Upper window in oscillator cycles.
  reg [31:0]           ratio_w;      // Selected divisor in tenths.
  reg [31:0]           lower_w;      // Lower boundary in cycles.
  wire                 trig_edge;    // Rising edge of the trigger.
  wire                 accept;       // Trigger taken on this tick.
  wire                 too_early;    // Accepted trigger before lower.
  wire                 too_late;     // Upper window expired.

  //////////////////////////////////////////////////////////////////////////
  // Input synchronisers.
  //////////////////////////////////////////////////////////////////////////

  // Pins pass two flip-flops; the third trigger stage keeps history.
  always @(posedge clk)
  begin
    if (rst)
    begin
      trig_sync_q <= 3'h0;
      cfg_meta_q  <= 3'h0;
      cfg_sync_q  <= 3'h0;
      cap_meta_q  <= {`CAP_W{1'b0}};
      cap_sync_q  <= {`CAP_W{1'b0}};
    end
    else
    begin
      trig_sync_q <= {trig_sync_q[1:0], trigger_input};
      cfg_meta_q  <= {cap_present, timeout_select, ratio_select};
      cfg_sync_q  <= cfg_meta_q;
      cap_meta_q  <= cap_pf;
      cap_sync_q  <= cap_meta_q;
    end
  end

  // A rising edge seen between the second and third stages.
  assign trig_edge = trig_sync_q[1] & ~trig_sync_q[2];

  //////////////////////////////////////////////////////////////////////////
  // Free-running window oscillator.
  //////////////////////////////////////////////////////////////////////////

  // The divider never restarts on a trigger, so phase is unknown to it.
  always @(posedge clk)
  begin
    if (rst)
    begin
      osc_cnt_q  <= 32'h0;
      osc_tick_q <= 1'b0;
    end
    else if (osc_cnt_q == OSC_TICK_CYC - 1)
    begin
      osc_cnt_q  <= 32'h0;
      osc_tick_q <= 1'b1;
    end
    else
    begin
      osc_cnt_q  <= osc_cnt_q + 32'h1;
      osc_tick_q <= 1'b0;
    end
  end

  // An edge waits for the next oscillator cycle; a new edge beats clear.
  always @(posedge clk)
  begin
    if (rst)
      pend_q <= 1'b0;
    else
      pend_q <= trig_edge | (pend_q & ~osc_tick_q);
  end

  //////////////////////////////////////////////////////////////////////////
  // Window limits from the latched straps.
  //////////////////////////////////////////////////////////////////////////

  // Upper window and lower divisor chosen from the latched straps.
  always @*
  begin
    upper_w = `WIN_SHORT_TICKS;
    ratio_w = `RATIO_LO_SHORT_X10;
    if (cfg_cap_q)
    begin
      upper_w = ((({16'h0, cfg_pf_q} * `CAP_PF_TO_X100) / `CAP_SCALE_X100)
                 + 32'h1) * `CAP_UNIT_TICKS;
      ratio_w = cfg_ratio_q ? `RATIO_HI_CAP_X10
                            : `RATIO_LO_CAP_X10;
    end
    else if (cfg_long_q)
    begin
      upper_w = `WIN_LONG_TICKS;
      ratio_w = cfg_ratio_q ? `RATIO_HI_LONG_X10
                            : `RATIO_LO_LONG_X10;
    end
    else
    begin
      upper_w = `WIN_SHORT_TICKS;
      ratio_w = cfg_ratio_q ? `RATIO_HI_SHORT_X10
                            : `RATIO_LO_SHORT_X10;
    end
    lower_w = (upper_w * `RATIO_SCALE) / ratio_w;
  end

  // Trigger acceptance and the two violation kinds.
  assign accept    = (state_q == ST_RUN) & osc_tick_q & pend_q;
  assign too_early = accept & ~first_q &
                     ({8'h0, win_cnt_q} < lower_w);
  assign too_late  = (state_q == ST_RUN) & osc_tick_q & ~accept &
                     ({8'h0, win_cnt_q} + 32'h1 >= upper_w);

  //////////////////////////////////////////////////////////////////////////
  // Watchdog state machine.
  //////////////////////////////////////////////////////////////////////////

  // Holds reset for the delay, then runs the window until a violation.
  always @(posedge clk)
  begin
    if (rst)
    begin
      state_q       <= ST_HOLD;
      hold_cnt_q    <= 32'h0;
      win_cnt_q     <= {`WIN_CNT_W{1'b0}};
      first_q       <= 1'b1;
      reset_n       <= 1'b0;
      reset_drive_n <= 1'b0;
      early_fault   <= 1'b0;
      late_fault    <= 1'b0;
      cfg_long_q    <= 1'b0;
      cfg_cap_q     <= 1'b0;
      cfg_ratio_q   <= 1'b0;
      cfg_pf_q      <= {`CAP_W{1'b0}};
    end
    else
    begin
      early_fault <= 1'b0;
      late_fault  <= 1'b0;
      case (state_q)
        ST_HOLD:
        begin
          // Output stays low until the delay has run out.
          if (hold_cnt_q == RESET_DELAY_CYC - 1)
          begin
            state_q       <= ST_RUN;
            hold_cnt_q    <= 32'h0;
            win_cnt_q     <= {`WIN_CNT_W{1'b0}};
            first_q       <= 1'b1;
            reset_n       <= 1'b1;
            reset_drive_n <= 1'b1;
            cfg_ratio_q   <= cfg_sync_q[0];
            cfg_long_q    <= cfg_sync_q[1];
            cfg_cap_q     <= cfg_sync_q[2];
            cfg_pf_q      <= cap_sync_q;
          end
          else
            hold_cnt_q <= hold_cnt_q + 32'h1;
        end
        ST_RUN:
        begin
          if (too_early | too_late)
          begin
            // Any violation pulls reset low and restarts the delay.
            state_q       <= ST_HOLD;
            hold_cnt_q    <= 32'h0;
            reset_n       <= 1'b0;
            reset_drive_n <= 1'b0;
            early_fault   <= too_early;
            late_fault    <= too_late;
          end
          else if (accept)
          begin
            // A good trigger clears the window counter and arms the lower check.
            win_cnt_q <= {`WIN_CNT_W{1'b0}};
            first_q   <= 1'b0;
          end
          else if (osc_tick_q)
            win_cnt_q <= win_cnt_q + {{(`WIN_CNT_W-1){1'b0}}, 1'b1};
        end
        default:
        begin
          state_q       <= ST_HOLD;
          hold_cnt_q    <= 32'h0;
          reset_n       <= 1'b0;
          reset_drive_n <= 1'b0;
        end
      endcase
    end
  end

endmodule // window_watchdog

// >>> test/window_watchdog_asserts.sv
// Checker for the window watchdog port behaviour.
`timescale 1ns/1ns
`include "window_watchdog_defines.vh"
module window_watchdog_asserts #(
  parameter RESET_DELAY_CYC = 20,
  parameter OSC_TICK_CYC    = 2
) (
  input wire              clk,
  input wire              rst,
  input wire              trigger_input,
  input wire              timeout_select,
  input wire              cap_present,
  input wire [`CAP_W-1:0] cap_pf,
  input wire              ratio_select,
  input wire              reset_n,
  input wire              reset_drive_n,
  input wire              early_fault,
  input wire              late_fault
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  reg [31:0] low_q; // Cycles the reset output has been seen low.
  reg        flt_q; // Set while a hold was started by a fault.
  // Helper counters; a hold after rst is not counted as fault hold.
  always @(posedge clk)
  begin
    low_q <= (rst || reset_n) ? 32'h0 : low_q + 32'h1;
    flt_q <= !rst && (early_fault || late_fault || (flt_q && !reset_n));
  end
  a_drive_tracks_level:
    assert property (reset_drive_n == reset_n)
    else $error("drive enable differs from reset level");
  a_early_drops_reset:
    assert property (early_fault |-> !reset_n && $past(reset_n))
    else $error("early fault without reset falling");
  a_late_drops_reset:
    assert property (late_fault |-> !reset_n && $past(reset_n))
    else $error("late fault without reset falling");
  a_fault_one_pulse:
    assert property ((early_fault || late_fault) |=>
                     !(early_fault || late_fault))
    else $error("fault pulse longer than one cycle");
  a_fall_needs_fault:
    assert property ($fell(reset_n) |-> early_fault || late_fault)
    else $error("reset fell without a fault");
  a_hold_exact_len:
    assert property ($rose(reset_n) && flt_q |-> low_q == RESET_DELAY_CYC)
    else $error("reset hold length wrong");
  a_hold_stays_low:
    assert property ($fell(reset_n) |=> !reset_n [*8])
    else $error("reset released too soon");
  a_quiet_in_hold:
    assert property (!reset_n && !$fell(reset_n) |->
                     !early_fault && !late_fault)
    else $error("fault flagged during hold");
  c_early: cover property (early_fault);
  c_late: cover property (late_fault);
  c_release: cover property ($rose(reset_n) && flt_q);
endmodule // window_watchdog_asserts

bind window_watchdog window_watchdog_asserts #(
  .RESET_DELAY_CYC(RESET_DELAY_CYC), .OSC_TICK_CYC(OSC_TICK_CYC)
) i_window_watchdog_asserts (
  .clk(clk), .rst(rst), .trigger_input(trigger_input),
  .timeout_select(timeout_select), .cap_present(cap_present),
  .cap_pf(cap_pf), .ratio_select(ratio_select), .reset_n(reset_n),
  .reset_drive_n(reset_drive_n), .early_fault(early_fault),
  .late_fault(late_fault));

// >>> test/proc_model.sv
// Supervised processor model that drives the trigger pin.
`timescale 1ns/1ns
module proc_model (
  input wire clk,
  output reg trigger_input
);
  // The pin idles low until the first kick.
  initial trigger_input = 1'b0;
  // Waits gap clocks, then pulses the pin high for three clocks.
  task automatic kick(input int gap);
  begin
    repeat (gap) @(posedge clk);
    #10 trigger_input = 1'b1;
    repeat (3) @(posedge clk);
    #10 trigger_input = 1'b0;
  end
  endtask
endmodule // proc_model

// >>> test/tb_top.sv
// Self-checking bench for the window watchdog timing block.
`timescale 1ns/1ns
`include "window_watchdog_defines.vh"
module tb_top;
  localparam int N = 20; // Short reset hold.
  localparam int T = 2;  // Clocks per oscillator tick.
  reg              clk, rst, timeout_select, cap_present, ratio_select;
  reg [`CAP_W-1:0] cap_pf;
  wire             trigger_input, reset_n, reset_drive_n;
  wire             early_fault, late_fault;
  int              n_errors = 0, samples_checked = 0;
  int              n_early = 0, n_late = 0, cyc = 0;
  window_watchdog #(.RESET_DELAY_CYC(N), .OSC_TICK_CYC(T)) i_window_watchdog (
    .clk(clk), .rst(rst), .trigger_input(trigger_input),
    .timeout_select(timeout_select), .cap_present(cap_present),
    .cap_pf(cap_pf), .ratio_select(ratio_select), .reset_n(reset_n),
    .reset_drive_n(reset_drive_n), .early_fault(early_fault),
    .late_fault(late_fault));
  proc_model i_proc_model (.clk(clk), .trigger_input(trigger_input));
  // Free running 10 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Counts fault pulses and cuts a hang short.
  always @(posedge clk)
  begin
    n_early += (early_fault === 1'b1);
    n_late += (late_fault === 1'b1);
    cyc += 1;
    if (cyc == 80000)
    begin
      n_errors += 1;
      summarize();
    end
  end
  // Compares a design level.
  task automatic chk_bit(input string what, input logic exp, input logic got);
  begin
    samples_checked += 1;
    if (got !== exp)
    begin
      n_errors += 1;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  end
  endtask
  // Compares a count of observed events.
  task automatic chk_cnt(input string what, input int exp, input int got);
  begin
    samples_checked += 1;
    if (got != exp)
    begin
      n_errors += 1;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
    end
  end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic summarize;
  begin
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask
  // Resets with new straps and checks the reset hold.
  task automatic restart(input logic ts, input logic cp, input logic rs);
  begin
    @(posedge clk);
    #10 rst = 1'b1;
    timeout_select = ts;
    cap_present = cp;
    ratio_select = rs;
    repeat (4) @(posedge clk);
    #10 rst = 1'b0;
    repeat (N - 2) @(posedge clk);
    #10 chk_bit("reset_n in hold", 1'b0, reset_n);
    chk_bit("reset_drive_n in hold", 1'b0, reset_drive_n);
    repeat (4) @(posedge clk);
    #10 chk_bit("reset_n after hold", 1'b1, reset_n);
    chk_bit("reset_drive_n after hold", 1'b1, reset_drive_n);
  end
  endtask
  // Strap sets 0 to 5 (cap, long, ratio bits): kick just after, then just before, the lower bound.
  task automatic t_lower_boundary;
    logic [2:0] c;
    int up, rat, lo, e0;
  begin
    for (int i = 0; i < 6; i++)
    begin
      c = i[2:0];
      up = c[2] ? (cap_pf * `CAP_PF_TO_X100 / `CAP_SCALE_X100 + 1)
         * `CAP_UNIT_TICKS : c[1] ? `WIN_LONG_TICKS : `WIN_SHORT_TICKS;
      rat = c[2] ? (c[0] ? `RATIO_HI_CAP_X10 : `RATIO_LO_CAP_X10)
          : c[1] ? (c[0] ? `RATIO_HI_LONG_X10 : `RATIO_LO_LONG_X10)
          : (c[0] ? `RATIO_HI_SHORT_X10 : `RATIO_LO_SHORT_X10);
      lo = up * `RATIO_SCALE / rat;
      restart(c[1], c[2], c[0]);
      e0 = n_early;
      i_proc_model.kick(2);
      i_proc_model.kick(T * (lo + 4));
      // Let the next oscillator tick take the edge before judging it.
      repeat (2 * T) @(posedge clk);
      #10 chk_cnt("early in window", e0, n_early);
      // The gap allows for the wait above; the edge lands below lower.
      i_proc_model.kick(T * (lo - 6));
      repeat (4 * T) @(posedge clk);
      #10 chk_cnt("early kick", e0 + 1, n_early);
      chk_bit("reset_n after early", 1'b0, reset_n);
    end
  end
  endtask
  // Missing kick, release, then a first kick and a too quick second.
  task automatic t_late_and_restart;
    int up, l0, e0;
  begin
    up = (cap_pf * `CAP_PF_TO_X100 / `CAP_SCALE_X100 + 1) * `CAP_UNIT_TICKS;
    restart(1'b0, 1'b1, 1'b1);
    l0 = n_late;
    e0 = n_early;
    i_proc_model.kick(2);
    repeat (T * (up - 4)) @(posedge clk);
    #10 chk_cnt("late too soon", l0, n_late);
    repeat (T * 8) @(posedge clk);
    #10 chk_cnt("late at upper", l0 + 1, n_late);
    chk_bit("reset_n after late", 1'b0, reset_n);
    repeat (N + 2) @(posedge clk);
    #10 chk_bit("reset_n released", 1'b1, reset_n);
    i_proc_model.kick(2);
    // The edge is taken on the next tick; judge it only after that.
    repeat (2 * T) @(posedge clk);
    #10 chk_cnt("first kick free", e0, n_early);
    i_proc_model.kick(2 * T);
    repeat (4 * T) @(posedge clk);
    #10 chk_cnt("second kick early", e0 + 1, n_early);
  end
  endtask
  // Main sequence.
  initial
  begin
    rst = 1'b1;
    timeout_select = 1'b0;
    cap_present = 1'b0;
    ratio_select = 1'b0;
    cap_pf = 16'h0020;
    t_lower_boundary();
    t_late_and_restart();
    summarize();
  end
endmodule // tb_top
